// ==== design/oabd_pkg.sv ====
// Constants, field layouts and types for the operand address byte decoder
// *****************************************************************************
// How it works
// - Addressing byte splits into mode bits 7-6, aux bits 5-3, r/m bits 2-0.
// - Mode 11 makes the r/m field name a general register, no memory.
// - Mode 00 carries no displacement bytes; displacement is zero, bar direct form.
// - Mode 01 fetches one displacement byte, sign-extended to sixteen bits.
// - Mode 10 fetches two displacement bytes, second byte is the high half.
// - Byte register codes 0-7 map to AL, CL, DL, BL, AH, CH, DH, BH.
// - Word register codes 0-7 map to AX, CX, DX, BX, SP, BP, SI, DI.
// - Memory r/m codes 0-2 address BX+SI, BX+DI, BP+SI plus displacement.
// - Mode 00 with r/m 110 takes a sixteen-bit direct address instead.
// - Displacement is added to the offset part, never to the segment.
// - Immediate data is at most sixteen bits from the immediate bytes.
// - Prefix 001ss110 overrides segment with ES, CS, SS, DS for ss 0-3.
// - Extension notation reads the aux field as a sub-operation selector.
// - Register notation reads the aux field as a byte or word register.
// - Immediate byte or word is signed or unsigned as the opcode says.
// - Offset opcodes take one offset byte, or a double word offset and segment.
// - Register-in-opcode forms take a word register from the opcode low bits.
// - String source is addressed by DS:SI, destination by ES:DI.
// *****************************************************************************
package oabd_pkg;

  // Addressing byte field positions
  localparam int MOD_MSB = 7;
  localparam int MOD_LSB = 6;
  localparam int AUX_MSB = 5;
  localparam int AUX_LSB = 3;
  localparam int RM_MSB = 2;
  localparam int RM_LSB = 0;

  // Mode field values
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // Word register codes
  localparam logic [2:0] REG_AX = 3'h0;
  localparam logic [2:0] REG_CX = 3'h1;
  localparam logic [2:0] REG_DX = 3'h2;
  localparam logic [2:0] REG_BX = 3'h3;
  localparam logic [2:0] REG_SP = 3'h4;
  localparam logic [2:0] REG_BP = 3'h5;
  localparam logic [2:0] REG_SI = 3'h6;
  localparam logic [2:0] REG_DI = 3'h7;

  // Segment override prefix pattern and segment codes
  localparam logic [7:0] PFX_MASK = 8'he7;
  localparam logic [7:0] PFX_MATCH = 8'h26;
  localparam int PFX_SEG_LSB = 3;
  localparam logic [1:0] SEG_ES = 2'h0;
  localparam logic [1:0] SEG_CS = 2'h1;
  localparam logic [1:0] SEG_SS = 2'h2;
  localparam logic [1:0] SEG_DS = 2'h3;

  // Offset byte counts, last byte index
  localparam logic [1:0] OFS_LAST_BYTE = 2'h0;
  localparam logic [1:0] OFS_LAST_DWORD = 2'h3;

  // Immediate and offset operand kinds
  typedef enum logic [1:0] {
    IMM_NONE = 2'h0,
    IMM_BYTE = 2'h1,
    IMM_WORD = 2'h2
  } oabd_imm_t;

  typedef enum logic [1:0] {
    OFS_NONE = 2'h0,
    OFS_BYTE = 2'h1,
    OFS_DWORD = 2'h2
  } oabd_ofs_t;

  // Decoder sequence
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_MODRM = 4'h1,
    ST_DISPLO = 4'h2,
    ST_DISPHI = 4'h3,
    ST_IMMLO = 4'h4,
    ST_IMMHI = 4'h5,
    ST_OFS = 4'h6,
    ST_REGRD = 4'h7,
    ST_CALC = 4'h8
  } oabd_state_t;

endpackage : oabd_pkg

// ==== design/oabd_rf_if.sv ====
// Read-port bundle between the decoder and the general register file
`timescale 1ns/1ps
interface oabd_rf_if #(
  parameter int WIDTH = 16,
  parameter int ADDR_W = 3
);
  logic [ADDR_W-1:0] rdAddrA;
  logic [ADDR_W-1:0] rdAddrB;
  logic [WIDTH-1:0] rdDataA;
  logic [WIDTH-1:0] rdDataB;

  modport decoder (output rdAddrA, output rdAddrB, input rdDataA, input rdDataB);
  modport regfile (input rdAddrA, input rdAddrB, output rdDataA, output rdDataB);
endinterface : oabd_rf_if

// ==== design/oabd_reg_file.sv ====
// General word register file with two registered read ports
`timescale 1ns/1ps
module oabd_reg_file #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int ADDR_W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  oabd_rf_if.regfile rf
);

  if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_bad_depth
    $error("oabd_reg_file: DEPTH does not fit ADDR_W");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; contents are set by the execution side
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  // Read data registered, one cycle after the address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rf.rdDataA <= '0;
      rf.rdDataB <= '0;
    end else begin
      rf.rdDataA <= mem[rf.rdAddrA];
      rf.rdDataB <= mem[rf.rdAddrB];
    end
  end

endmodule : oabd_reg_file

// ==== design/oabd_decoder.sv ====
// Operand address byte decoder: field split, displacement, immediates, segment
`timescale 1ns/1ps
module oabd_decoder #(
  parameter int WORD_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic descValid,
  input wire logic [7:0] descOpcode,
  input wire logic descHasModrm,
  input wire logic descWordOp,
  input wire logic descExtNote,
  input wire logic [1:0] descImm,
  input wire logic descImmSigned,
  input wire logic [1:0] descOffset,
  input wire logic descRegInOpcode,
  input wire logic descString,
  output logic descReady,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [15:0] wrData,
  output logic decodeDone,
  output logic [1:0] modeField,
  output logic [2:0] auxField,
  output logic [2:0] rmField,
  output logic isRegOperand,
  output logic [2:0] rmRegIdx,
  output logic rmRegHigh,
  output logic extValid,
  output logic [2:0] extSelect,
  output logic auxRegValid,
  output logic [2:0] auxRegIdx,
  output logic auxRegHigh,
  output logic opcodeRegValid,
  output logic [2:0] opcodeRegIdx,
  output logic [15:0] displacement,
  output logic [15:0] effectiveOffset,
  output logic [1:0] segmentSelectBits,
  output logic segOverride,
  output logic immValid,
  output logic [15:0] immediate,
  output logic [1:0] offsetKind,
  output logic [15:0] offsetOperand,
  output logic [15:0] segmentOperand,
  output logic stringValid,
  output logic [15:0] stringDstOffset,
  output logic [1:0] stringDstSeg
);

  if (WORD_W != 16) begin : g_bad_width
    $error("oabd_decoder: only a 16-bit word is supported");
  end

  // ***************************************************************************
  // Functions
  // ***************************************************************************

  // Next step once displacement is done: immediates first, then offsets
  function automatic oabd_pkg::oabd_state_t afterDisp(input logic [1:0] imm,
                                                       input logic [1:0] ofs);
    if (imm != oabd_pkg::IMM_NONE) begin
      return oabd_pkg::ST_IMMLO;
    end else if (ofs != oabd_pkg::OFS_NONE) begin
      return oabd_pkg::ST_OFS;
    end else begin
      return oabd_pkg::ST_REGRD;
    end
  endfunction : afterDisp

  // Base register of a memory form, {used, index}
  function automatic logic [3:0] eaBase(input logic [2:0] rm);
    case (rm)
      3'h0, 3'h1: return {1'b1, oabd_pkg::REG_BX};
      3'h2, 3'h3: return {1'b1, oabd_pkg::REG_BP};
      3'h4: return {1'b1, oabd_pkg::REG_SI};
      3'h5: return {1'b1, oabd_pkg::REG_DI};
      3'h6: return {1'b1, oabd_pkg::REG_BP};
      default: return {1'b1, oabd_pkg::REG_BX};
    endcase
  endfunction : eaBase

  // Index register of a memory form, {used, index}
  function automatic logic [3:0] eaIndex(input logic [2:0] rm);
    case (rm)
      3'h0, 3'h2: return {1'b1, oabd_pkg::REG_SI};
      3'h1, 3'h3: return {1'b1, oabd_pkg::REG_DI};
      default: return {1'b0, oabd_pkg::REG_AX};
    endcase
  endfunction : eaIndex

  // Byte register code to {high half, word register holding it}
  function automatic logic [3:0] regMap(input logic [2:0] code, input logic word);
    if (word) begin
      return {1'b0, code};
    end else begin
      return {code[2], 1'b0, code[1:0]};
    end
  endfunction : regMap

  // ***************************************************************************
  // Latched descriptor and fields
  // ***************************************************************************

  oabd_pkg::oabd_state_t state_q, state_d;
  logic byteTake;
  logic [7:0] opcode_q;
  logic hasModrm_q, wordOp_q, extNote_q, immSigned_q, regInOpcode_q, string_q;
  logic [1:0] immKind_q, ofsKind_q;
  logic [1:0] mode_q;
  logic [2:0] aux_q, rm_q;
  logic [15:0] disp_q;
  logic [15:0] imm_q;
  logic [31:0] ofsBuf_q;
  logic [1:0] ofsCnt_q;
  logic ovrValid_q;
  logic [1:0] ovrSeg_q;
  logic direct, isPrefix;
  logic [3:0] baseSel, indexSel;
  logic [15:0] eaSum;
  logic [1:0] memSeg;
  logic [3:0] rmMap, auxMap;

  oabd_rf_if #(.WIDTH(16), .ADDR_W(3)) rf ();

  oabd_reg_file #(.WIDTH(16), .DEPTH(8), .ADDR_W(3)) u_reg_file (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .rf(rf.regfile)
  );

  assign byteTake = byteValid && byteReady;
  assign isPrefix = (byteData & oabd_pkg::PFX_MASK) == oabd_pkg::PFX_MATCH;
  assign direct = (mode_q == oabd_pkg::MOD_NODISP) && (rm_q == oabd_pkg::RM_DIRECT);
  assign baseSel = eaBase(rm_q);
  assign indexSel = eaIndex(rm_q);

  // String forms read SI and DI; memory forms read base and index
  assign rf.rdAddrA = string_q ? oabd_pkg::REG_SI : baseSel[2:0];
  assign rf.rdAddrB = string_q ? oabd_pkg::REG_DI : indexSel[2:0];

  // Displacement joins the offset only; segment is chosen apart
  always_comb begin
    if (direct) begin
      eaSum = disp_q;
    end else begin
      eaSum = (baseSel[3] ? rf.rdDataA : 16'h0000) + (indexSel[3] ? rf.rdDataB : 16'h0000)
            + disp_q;
    end
  end

  // BP-based memory forms and mode 11 with r/m 2, 3, 6 default to SS, all else to DS; a prefix wins
  always_comb begin
    if (ovrValid_q) begin
      memSeg = ovrSeg_q;
    end else if (!string_q && !direct && baseSel[2:0] == oabd_pkg::REG_BP) begin
      memSeg = oabd_pkg::SEG_SS;
    end else begin
      memSeg = oabd_pkg::SEG_DS;
    end
  end

  assign rmMap = regMap(rm_q, wordOp_q);
  assign auxMap = regMap(aux_q, wordOp_q);

  // ***************************************************************************
  // Sequencer
  // ***************************************************************************

  // Next step: idle advances on a descriptor, byte states on taken bytes, REGRD and CALC after one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      oabd_pkg::ST_IDLE: begin
        if (descValid && descReady) begin
          state_d = descHasModrm ? oabd_pkg::ST_MODRM : afterDisp(descImm, descOffset);
        end
      end
      oabd_pkg::ST_MODRM: begin
        if (byteTake) begin
          if (byteData[oabd_pkg::MOD_MSB:oabd_pkg::MOD_LSB] == oabd_pkg::MOD_REG ||
              (byteData[oabd_pkg::MOD_MSB:oabd_pkg::MOD_LSB] == oabd_pkg::MOD_NODISP &&
               byteData[oabd_pkg::RM_MSB:oabd_pkg::RM_LSB] != oabd_pkg::RM_DIRECT)) begin
            state_d = afterDisp(immKind_q, ofsKind_q);
          end else begin
            state_d = oabd_pkg::ST_DISPLO;
          end
        end
      end
      oabd_pkg::ST_DISPLO: begin
        if (byteTake) begin
          state_d = (mode_q == oabd_pkg::MOD_DISP8) ? afterDisp(immKind_q, ofsKind_q)
                                                    : oabd_pkg::ST_DISPHI;
        end
      end
      oabd_pkg::ST_DISPHI: begin
        if (byteTake) begin
          state_d = afterDisp(immKind_q, ofsKind_q);
        end
      end
      oabd_pkg::ST_IMMLO: begin
        if (byteTake) begin
          state_d = (immKind_q == oabd_pkg::IMM_WORD) ? oabd_pkg::ST_IMMHI
                                                      : afterDisp(oabd_pkg::IMM_NONE, ofsKind_q);
        end
      end
      oabd_pkg::ST_IMMHI: begin
        if (byteTake) begin
          state_d = afterDisp(oabd_pkg::IMM_NONE, ofsKind_q);
        end
      end
      oabd_pkg::ST_OFS: begin
        if (byteTake && ofsCnt_q == ((ofsKind_q == oabd_pkg::OFS_BYTE) ?
            oabd_pkg::OFS_LAST_BYTE : oabd_pkg::OFS_LAST_DWORD)) begin
          state_d = oabd_pkg::ST_REGRD;
        end
      end
      oabd_pkg::ST_REGRD: state_d = oabd_pkg::ST_CALC;
      oabd_pkg::ST_CALC: state_d = oabd_pkg::ST_IDLE;
      default: state_d = oabd_pkg::ST_IDLE;
    endcase
  end

  // State and handshake flops; readies follow the next state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= oabd_pkg::ST_IDLE;
      descReady <= 1'b0;
      byteReady <= 1'b0;
    end else begin
      state_q <= state_d;
      descReady <= (state_d == oabd_pkg::ST_IDLE);
      byteReady <= (state_d != oabd_pkg::ST_REGRD) && (state_d != oabd_pkg::ST_CALC);
    end
  end

  // Descriptor capture at instruction start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opcode_q <= 8'h00;
      hasModrm_q <= 1'b0;
      wordOp_q <= 1'b0;
      extNote_q <= 1'b0;
      immKind_q <= oabd_pkg::IMM_NONE;
      immSigned_q <= 1'b0;
      ofsKind_q <= oabd_pkg::OFS_NONE;
      regInOpcode_q <= 1'b0;
      string_q <= 1'b0;
    end else if (state_q == oabd_pkg::ST_IDLE && descValid && descReady) begin
      opcode_q <= descOpcode;
      hasModrm_q <= descHasModrm;
      wordOp_q <= descWordOp;
      extNote_q <= descExtNote;
      immKind_q <= descImm;
      immSigned_q <= descImmSigned;
      ofsKind_q <= descOffset;
      regInOpcode_q <= descRegInOpcode;
      string_q <= descString;
    end
  end

  // Addressing byte split; forms without one read as register mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= oabd_pkg::MOD_REG;
      aux_q <= 3'h0;
      rm_q <= 3'h0;
    end else if (state_q == oabd_pkg::ST_IDLE && descValid && descReady) begin
      mode_q <= oabd_pkg::MOD_REG;
      aux_q <= 3'h0;
      rm_q <= 3'h0;
    end else if (state_q == oabd_pkg::ST_MODRM && byteTake) begin
      mode_q <= byteData[oabd_pkg::MOD_MSB:oabd_pkg::MOD_LSB];
      aux_q <= byteData[oabd_pkg::AUX_MSB:oabd_pkg::AUX_LSB];
      rm_q <= byteData[oabd_pkg::RM_MSB:oabd_pkg::RM_LSB];
    end
  end

  // Displacement: zero by default, low byte first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp_q <= 16'h0000;
    end else if (state_q == oabd_pkg::ST_IDLE) begin
      disp_q <= 16'h0000;
    end else if (state_q == oabd_pkg::ST_DISPLO && byteTake) begin
      if (mode_q == oabd_pkg::MOD_DISP8) begin
        disp_q <= {{8{byteData[7]}}, byteData};
      end else begin
        disp_q <= {8'h00, byteData};
      end
    end else if (state_q == oabd_pkg::ST_DISPHI && byteTake) begin
      disp_q <= {byteData, disp_q[7:0]};
    end
  end

  // Immediate: byte widened per opcode signedness, word low byte first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      imm_q <= 16'h0000;
    end else if (state_q == oabd_pkg::ST_IMMLO && byteTake) begin
      imm_q <= {(immSigned_q ? {8{byteData[7]}} : 8'h00), byteData};
    end else if (state_q == oabd_pkg::ST_IMMHI && byteTake) begin
      imm_q <= {byteData, imm_q[7:0]};
    end
  end

  // Offset bytes: offset low, high, then segment low, high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ofsBuf_q <= 32'h00000000;
      ofsCnt_q <= 2'h0;
    end else if (state_q == oabd_pkg::ST_IDLE) begin
      ofsBuf_q <= 32'h00000000;
      ofsCnt_q <= 2'h0;
    end else if (state_q == oabd_pkg::ST_OFS && byteTake) begin
      ofsBuf_q[{ofsCnt_q, 3'h0} +: 8] <= byteData;
      ofsCnt_q <= ofsCnt_q + 2'h1;
    end
  end

  // Prefix seen while idle holds until its instruction completes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovrValid_q <= 1'b0;
      ovrSeg_q <= oabd_pkg::SEG_DS;
    end else if (state_q == oabd_pkg::ST_IDLE && byteTake && isPrefix) begin
      ovrValid_q <= 1'b1;
      ovrSeg_q <= byteData[oabd_pkg::PFX_SEG_LSB +: 2];
    end else if (state_q == oabd_pkg::ST_CALC) begin
      ovrValid_q <= 1'b0;
    end
  end

  // ***************************************************************************
  // Result registers, loaded in the final step
  // ***************************************************************************

  // Done pulse lasts one cycle; results stand until the next one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      decodeDone <= 1'b0;
    end else begin
      decodeDone <= (state_q == oabd_pkg::ST_CALC);
    end
  end

  // Field and register selections
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeField <= oabd_pkg::MOD_REG;
      auxField <= 3'h0;
      rmField <= 3'h0;
      isRegOperand <= 1'b0;
      rmRegIdx <= 3'h0;
      rmRegHigh <= 1'b0;
      extValid <= 1'b0;
      extSelect <= 3'h0;
      auxRegValid <= 1'b0;
      auxRegIdx <= 3'h0;
      auxRegHigh <= 1'b0;
      opcodeRegValid <= 1'b0;
      opcodeRegIdx <= 3'h0;
    end else if (state_q == oabd_pkg::ST_CALC) begin
      modeField <= mode_q;
      auxField <= aux_q;
      rmField <= rm_q;
      isRegOperand <= hasModrm_q && (mode_q == oabd_pkg::MOD_REG);
      rmRegIdx <= rmMap[2:0];
      rmRegHigh <= rmMap[3];
      extValid <= hasModrm_q && extNote_q;
      extSelect <= aux_q;
      auxRegValid <= hasModrm_q && !extNote_q;
      auxRegIdx <= auxMap[2:0];
      auxRegHigh <= auxMap[3];
      opcodeRegValid <= regInOpcode_q;
      opcodeRegIdx <= opcode_q[2:0];
    end
  end

  // Addresses, segment and operand values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      displacement <= 16'h0000;
      effectiveOffset <= 16'h0000;
      segmentSelectBits <= oabd_pkg::SEG_DS;
      segOverride <= 1'b0;
      immValid <= 1'b0;
      immediate <= 16'h0000;
      offsetKind <= oabd_pkg::OFS_NONE;
      offsetOperand <= 16'h0000;
      segmentOperand <= 16'h0000;
      stringValid <= 1'b0;
      stringDstOffset <= 16'h0000;
      stringDstSeg <= oabd_pkg::SEG_ES;
    end else if (state_q == oabd_pkg::ST_CALC) begin
      displacement <= disp_q;
      effectiveOffset <= string_q ? rf.rdDataA : eaSum;
      segmentSelectBits <= memSeg;
      segOverride <= ovrValid_q;
      immValid <= (immKind_q != oabd_pkg::IMM_NONE);
      immediate <= imm_q;
      offsetKind <= ofsKind_q;
      offsetOperand <= (ofsKind_q == oabd_pkg::OFS_BYTE) ? {8'h00, ofsBuf_q[7:0]}
                                                         : ofsBuf_q[15:0];
      segmentOperand <= ofsBuf_q[31:16];
      stringValid <= string_q;
      stringDstOffset <= rf.rdDataB;
      stringDstSeg <= oabd_pkg::SEG_ES;
    end
  end

endmodule : oabd_decoder

// ==== testbench/oabd_decoder_chk.sv ====
// Concurrent checks on the decoder top ports
`timescale 1ns/1ps
module oabd_decoder_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic descValid,
  input wire logic descReady,
  input wire logic decodeDone,
  input wire logic [1:0] modeField,
  input wire logic [2:0] auxField,
  input wire logic [2:0] rmField,
  input wire logic isRegOperand,
  input wire logic [2:0] rmRegIdx,
  input wire logic extValid,
  input wire logic [2:0] extSelect,
  input wire logic auxRegValid,
  input wire logic [2:0] auxRegIdx,
  input wire logic [15:0] displacement,
  input wire logic stringValid,
  input wire logic [1:0] stringDstSeg
);
  // ****
  // Handshake and decoded fields
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Bounded busy span, so a stuck sequencer cannot hide
  sequence takeS; descValid && descReady; endsequence
  sequence finishS; ##[3:60] decodeDone; endsequence
  take_done_a: assert property (takeS |-> finishS)
    else $error("decode never completed");
  busy_refuse_a: assert property (takeS |=> (!descReady) [*2])
    else $error("descriptor ready while busy");
  mode_reg_a: assert property (decodeDone && isRegOperand |-> modeField == 2'h3)
    else $error("register operand with memory mode");
  disp_zero_a: assert property (
    decodeDone && modeField == 2'h0 && rmField != 3'h6 |-> displacement == 16'h0)
    else $error("mode 0 displacement not zero");
  disp_sext_a: assert property (
    decodeDone && modeField == 2'h1 |-> displacement[15:8] == {8{displacement[7]}})
    else $error("short displacement not sign extended");
  rm_reg_a: assert property (
    decodeDone && isRegOperand |-> rmRegIdx[1:0] == rmField[1:0])
    else $error("r/m register index wrong");
  ext_sel_a: assert property (
    decodeDone && extValid |-> extSelect == auxField && !auxRegValid)
    else $error("extension selector wrong");
  aux_reg_a: assert property (
    decodeDone && auxRegValid |-> auxRegIdx[1:0] == auxField[1:0])
    else $error("aux register index wrong");
  str_seg_a: assert property (decodeDone && stringValid |-> stringDstSeg == 2'h0)
    else $error("string destination segment wrong");
endmodule : oabd_decoder_chk
bind oabd_decoder oabd_decoder_chk i_oabd_decoder_chk (.*);

// ==== testbench/oabd_fetch_model.sv ====
// Instruction byte source standing in for the fetch queue
`timescale 1ns/1ps
module oabd_fetch_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic byteReady,
  output logic byteValid,
  output logic [7:0] byteData
);
  logic [7:0] q[$];
  logic took = 1'b0;
  logic gap = 1'b0;
  // ****
  // Queue, offer and hold
  // ****
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  initial begin
    byteValid = 1'b0;
    byteData = 8'h5a;
  end
  // Taken when valid meets ready on the rising edge
  always @(posedge core_clk) took <= byteValid && byteReady;
  // Offer held until taken; idle data toggles so stale bytes never look fresh
  always @(negedge core_clk) begin
    if (took) void'(q.pop_front());
    if (!byteValid || took) begin
      gap = slow && !gap;
      byteValid = (q.size() != 0) && !gap;
      byteData = byteValid ? q[0] : ~byteData;
    end
  end
endmodule : oabd_fetch_model

// ==== testbench/oabd_decoder_test.sv ====
// Self-checking bench for the operand address byte decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module oabd_decoder_test;
  logic core_clk, rst, descValid, descHasModrm, descWordOp, descExtNote, descImmSigned;
  logic descRegInOpcode, descString, byteValid, byteReady, wrEn, descReady, decodeDone;
  logic isRegOperand, rmRegHigh, extValid, auxRegValid, auxRegHigh, opcodeRegValid, slow;
  logic segOverride, immValid, stringValid;
  logic [7:0] descOpcode, byteData;
  logic [1:0] descImm, descOffset, modeField, segmentSelectBits, offsetKind, stringDstSeg;
  logic [2:0] wrIdx, auxField, rmField, rmRegIdx, extSelect, auxRegIdx, opcodeRegIdx;
  logic [15:0] wrData, displacement, effectiveOffset, immediate, offsetOperand;
  logic [15:0] segmentOperand, stringDstOffset;
  logic [15:0] regs[8];
  int mismatches = 0;
  int n_compared = 0;
  oabd_decoder i_oabd_decoder (.*);
  oabd_fetch_model i_oabd_fetch_model (.*);
  // ****
  // Clock, expectations and bus tasks
  // ****
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Address sum for a memory operand
  function automatic logic [15:0] eaf(input logic [1:0] m, input logic [2:0] rm,
                                      input logic [15:0] d);
    case (rm)
      3'h0: return regs[3] + regs[6] + d;
      3'h1: return regs[3] + regs[7] + d;
      3'h2: return regs[5] + regs[6] + d;
      3'h3: return regs[5] + regs[7] + d;
      3'h4: return regs[6] + d;
      3'h5: return regs[7] + d;
      3'h6: return (m == 2'h0) ? d : regs[5] + d;
      default: return regs[3] + d;
    endcase
  endfunction : eaf
  task automatic wrReg(input logic [2:0] k, input logic [15:0] v);
    @(negedge core_clk);
    {wrEn, wrIdx, wrData} = {1'b1, k, v};
    regs[k] = v;
    @(negedge core_clk);
    wrEn = 1'b0;
  endtask : wrReg
  task automatic results();
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // One descriptor: corners first, random after
  task automatic one(input int i);
    logic [1:0] m, sg, ik, ok, sgx;
    logic [2:0] rm, ax;
    logic [7:0] op, d0, d1, i0, i1;
    logic [31:0] ob;
    logic hm, pf, wo, ex, sn, str, rio;
    logic [15:0] dsp;
    int k;
    {m, rm, ax, op, sg} = 18'($urandom);
    {d0, d1, i0, i1} = $urandom;
    ob = $urandom;
    {wo, ex, sn, pf} = 4'($urandom);
    ik = 2'($urandom_range(2));
    {hm, ok, str, rio} = {(i < 6 || i > 9), 2'h0, (i == 6), (i == 9)};
    if (i < 4) {m, rm, pf, sg} = {5'h06, 1'b1, 2'(i)};
    if (i == 4 || i == 5) {m, d0} = {2'h1, (i == 4) ? 8'h80 : 8'h7f};
    if (i == 7 || i == 8) ok = 2'(i - 6);
    dsp = (m == 2'h1) ? {{8{d0[7]}}, d0} : (m == 2'h2 || (m == 2'h0 && rm == 3'h6)) ?
          {d1, d0} : 16'h0;
    sgx = pf ? sg : (str || !(rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && m != 2'h0))) ?
          2'h3 : 2'h2;
    if (i[1]) wrReg(3'($urandom), 16'($urandom));
    // Prefix goes in alone while idle, so no later byte is dropped as idle noise
    if (pf) i_oabd_fetch_model.push({3'h1, sg, 3'h6});
    for (k = 0; k < 8 && i_oabd_fetch_model.q.size() != 0; k++) @(posedge core_clk);
    @(negedge core_clk);
    slow = i[0] ^ i[2];
    `CHK("readies", 2'h3, {descReady, byteReady})
    {descValid, descOpcode, descHasModrm, descWordOp, descExtNote, descImm, descImmSigned,
     descOffset, descRegInOpcode, descString} = {1'b1, op, hm, wo, ex, ik, sn, ok, rio, str};
    @(negedge core_clk);
    descValid = 1'b0;
    if (hm) i_oabd_fetch_model.push({m, ax, rm});
    if (hm && (m == 2'h1 || m == 2'h2 || m == 2'h0 && rm == 3'h6)) i_oabd_fetch_model.push(d0);
    if (hm && (m == 2'h2 || m == 2'h0 && rm == 3'h6)) i_oabd_fetch_model.push(d1);
    if (ik != 2'h0) i_oabd_fetch_model.push(i0);
    if (ik == 2'h2) i_oabd_fetch_model.push(i1);
    for (k = 0; k < 4 && ok != 2'h0; k++)
      if (k == 0 || ok == 2'h2) i_oabd_fetch_model.push(ob[8*k+:8]);
    for (k = 0; k < 60 && decodeDone !== 1'b1; k++) @(posedge core_clk) #1;
    `CHK("decodeDone", 1'b1, decodeDone)
    `CHK("isRegOperand", hm && m == 2'h3, isRegOperand)
    `CHK("fields", hm ? {m, ax, rm} : 8'hc0, {modeField, auxField, rmField})
    `CHK("valids", {hm && ex, hm && !ex, rio, str}, {extValid, auxRegValid, opcodeRegValid,
      stringValid})
    if (hm && ex) `CHK("extSelect", {1'b1, ax}, {extValid, extSelect})
    if (hm && !ex) `CHK("auxReg", {wo ? ax : {1'b0, ax[1:0]}, !wo && ax[2]},
      {auxRegIdx, auxRegHigh})
    if (hm && m == 2'h3) `CHK("rmReg", {wo ? rm : {1'b0, rm[1:0]}, !wo && rm[2]},
      {rmRegIdx, rmRegHigh})
    if (str || hm && m != 2'h3) `CHK("ea", str ? regs[6] : eaf(m, rm, dsp),
      effectiveOffset)
    if (str || hm && m != 2'h3) `CHK("segment", sgx, segmentSelectBits)
    `CHK("segOverride", pf, segOverride)
    if (hm && m != 2'h3 && !(m == 2'h0 && rm == 3'h6)) `CHK("disp", dsp, displacement)
    `CHK("immValid", ik != 2'h0, immValid)
    if (ik == 2'h1) `CHK("byte_immediate", sn ? {{8{i0[7]}}, i0} : {8'h0, i0}, immediate)
    if (ik == 2'h2) `CHK("word_immediate", {i1, i0}, immediate)
    `CHK("offsetKind", ok, offsetKind)
    if (ok == 2'h1) `CHK("ofs8", {8'h0, ob[7:0]}, offsetOperand)
    if (ok == 2'h2) `CHK("ofs32", ob, {segmentOperand, offsetOperand})
    if (rio) `CHK("opcodeReg", {1'b1, op[2:0]}, {opcodeRegValid, opcodeRegIdx})
    if (str) `CHK("stringDst", {regs[7], 2'h0}, {stringDstOffset, stringDstSeg})
  endtask : one
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    {descValid, descOpcode, descHasModrm, descWordOp, descExtNote, descImm, descImmSigned,
     descOffset, descRegInOpcode, descString, wrEn, wrIdx, wrData, slow} = '0;
    rst = 1'b1;
    void'($urandom(72));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int r = 0; r < 8; r++) wrReg(3'(r), 16'($urandom));
    for (int i = 0; i < 60; i++) one(i);
    results();
  end
  // About 60 decodes of under 50 cycles each; allow twice that
  initial begin
    #120000;
    mismatches++;
    results();
  end
endmodule : oabd_decoder_test
